// [logic/field_classify.sv]
`include "field_dec_consts.svh"

// Pure combinational split and classification of one field encoding.
module field_classify (
    input wire logic [31:0] enc,
    output field_dec_pkg::width_e width,
    output field_dec_pkg::type_e ftype,
    output logic [8:0] index,
    output logic high,
    output field_dec_pkg::sel_e sel,
    output logic invalid
);

    logic rsvd_clear;
    logic is_64;
    logic is_ctrl;
    logic is_guest;

    // Split the encoding into its fields.
    always_comb begin
        width = field_dec_pkg::width_e'(enc[`ENC_WIDTH_MSB:`ENC_WIDTH_LSB]);
        ftype = field_dec_pkg::type_e'(enc[`ENC_TYPE_MSB:`ENC_TYPE_LSB]);
        index = enc[`ENC_INDEX_MSB:`ENC_INDEX_LSB]; // see RULE_06
        high = enc[`ENC_ACCESS_BIT]; // see RULE_03
        rsvd_clear = (enc[31:`ENC_UPPER_LSB] == 17'h0_0000) &&
            !enc[`ENC_RSVD_BIT];
    end

    // Only 64-bit control fields with a known index select storage.
    // Guest-state 64-bit fields are recognised but none is stored here,
    // so they still report invalid rather than alias a control field.
    always_comb begin
        is_64 = (enc[`ENC_WIDTH_MSB:`ENC_WIDTH_LSB] == `WIDTH_CODE_64); // see RULE_01
        is_ctrl = (enc[`ENC_TYPE_MSB:`ENC_TYPE_LSB] == `TYPE_CODE_CTRL); // see RULE_05
        is_guest = (enc[`ENC_TYPE_MSB:`ENC_TYPE_LSB] == `TYPE_CODE_GUEST); // see RULE_09
        sel = field_dec_pkg::SEL_NONE;
        if (rsvd_clear && is_64 && is_ctrl) begin // see RULE_02
            if (index == `IDX_BITMAP_A) begin
                sel = field_dec_pkg::SEL_BITMAP_A; // see RULE_07
            end else if (index == `IDX_BITMAP_B) begin
                sel = field_dec_pkg::SEL_BITMAP_B; // see RULE_08
            end
        end
        invalid = (sel == field_dec_pkg::SEL_NONE) || !(is_ctrl || is_guest); // see RULE_11
    end

endmodule // field_classify

// [logic/field_dec_consts.svh]
`ifndef FIELD_DEC_CONSTS_SVH
`define FIELD_DEC_CONSTS_SVH

// Bit positions inside a 32-bit field encoding.
`define ENC_ACCESS_BIT 0
`define ENC_INDEX_LSB 1
`define ENC_INDEX_MSB 9
`define ENC_TYPE_LSB 10
`define ENC_TYPE_MSB 11
`define ENC_RSVD_BIT 12
`define ENC_WIDTH_LSB 13
`define ENC_WIDTH_MSB 14
`define ENC_UPPER_LSB 15

// Width and type codes as they sit in the encoding.
`define WIDTH_CODE_16 2'h0
`define WIDTH_CODE_64 2'h1
`define TYPE_CODE_CTRL 2'h0
`define TYPE_CODE_GUEST 2'h2

// Indices and full-access and upper-half encodings of the two bitmap address fields.
`define IDX_BITMAP_A 9'h000
`define IDX_BITMAP_B 9'h001
`define ENC_BITMAP_A_FULL 32'h0000_2000
`define ENC_BITMAP_A_HIGH 32'h0000_2001
`define ENC_BITMAP_B_FULL 32'h0000_2002
`define ENC_BITMAP_B_HIGH 32'h0000_2003

// Reset values of the stored fields.
`define BITMAP_RESET 64'h0000_0000_0000_0000

`endif

// [logic/field_dec_pkg.sv]
package field_dec_pkg;

    // Width class of an encoding, codes as in bits 14:13.
    typedef enum logic [1:0] {
        WIDTH_16 = 2'b00,
        WIDTH_64 = 2'b01,
        WIDTH_32 = 2'b10,
        WIDTH_NAT = 2'b11
    } width_e;

    // Field type group, codes as in bits 11:10.
    typedef enum logic [1:0] {
        TYPE_CTRL = 2'b00,
        TYPE_EXIT = 2'b01,
        TYPE_GUEST = 2'b10,
        TYPE_HOST = 2'b11
    } type_e;

    // Selected stored field.
    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_BITMAP_A = 2'b01,
        SEL_BITMAP_B = 2'b10,
        SEL_SPARE = 2'b11
    } sel_e;

endpackage

// [logic/wide_vm_field_encoding_decoder.sv]
// What this block does
// RULE_01: Width bits 14:13 equal to one mark a 64-bit field.
// RULE_02: 64-bit fields exist only for control and guest-state types.
// RULE_03: Each 64-bit field has two encodings differing only in bit 0.
// RULE_04: Even encoding accesses the whole field, odd one the upper half.
// RULE_05: Type bits 11:10 equal to zero mean a control field.
// RULE_06: Index bits 9:1 tell fields of one width and type apart.
// RULE_07: First bitmap address field is 0x2000 full, 0x2001 upper half.
// RULE_08: Second bitmap address field, index one, is 0x2002 and 0x2003.
// RULE_09: Type bits 11:10 equal to two mean a guest-state field.
// RULE_10: Width bits 14:13 equal to zero mark a 16-bit field.
// RULE_11: Unsupported encodings raise invalid and select no field.
`include "field_dec_consts.svh"

module wide_vm_field_encoding_decoder (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [31:0] req_enc,
    input wire logic [63:0] req_wdata,
    output logic rsp_valid,
    output logic rsp_invalid,
    output logic rsp_is_64,
    output logic rsp_is_16,
    output logic rsp_is_ctrl,
    output logic rsp_is_guest,
    output logic rsp_high,
    output logic [8:0] rsp_index,
    output field_dec_pkg::sel_e rsp_sel,
    output logic [63:0] rsp_rdata,
    output logic [15:0] invalid_count
);

    ////////////////////////////////////////////////////////////////////////
    // Encoding split and field lookup.

    field_dec_pkg::width_e dec_width;
    field_dec_pkg::type_e dec_type;
    logic [8:0] dec_index;
    logic dec_high;
    field_dec_pkg::sel_e dec_sel;
    logic dec_invalid;

    field_classify u_classify (
        .enc(req_enc),
        .width(dec_width),
        .ftype(dec_type),
        .index(dec_index),
        .high(dec_high),
        .sel(dec_sel),
        .invalid(dec_invalid)
    );

    ////////////////////////////////////////////////////////////////////////
    // Helpers shared by the read and write paths.

    // Upper-half access moves the high word into the low 32 bits and
    // returns zero above, so software sees a plain 32-bit quantity.
    function automatic logic [63:0] read_view(input logic [63:0] value,
                                              input logic upper);
        logic [63:0] result;
        result = value;
        if (upper) begin
            result = {32'h0000_0000, value[63:32]};
        end
        return result;
    endfunction

    // An upper-half write only touches bits 63:32; the low word survives.
    function automatic logic [63:0] write_merge(input logic [63:0] old,
                                                input logic [63:0] data,
                                                input logic upper);
        logic [63:0] result;
        result = data;
        if (upper) begin
            result = {data[31:0], old[31:0]};
        end
        return result;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Stored field state.

    logic [63:0] bitmap_a_r;
    logic [63:0] bitmap_a_nxt;
    logic [63:0] bitmap_b_r;
    logic [63:0] bitmap_b_nxt;

    // Writes land on the edge that takes the request, so a read issued in
    // the next cycle already returns the new value.
    always_comb begin
        bitmap_a_nxt = bitmap_a_r;
        bitmap_b_nxt = bitmap_b_r;
        if (req_valid && req_write && !dec_invalid) begin
            case (dec_sel)
                field_dec_pkg::SEL_BITMAP_A: begin
                    bitmap_a_nxt = write_merge(bitmap_a_r, req_wdata,
                                               dec_high); // see RULE_04
                end
                field_dec_pkg::SEL_BITMAP_B: begin
                    bitmap_b_nxt = write_merge(bitmap_b_r, req_wdata,
                                               dec_high); // see RULE_04
                end
                default: begin
                    bitmap_a_nxt = bitmap_a_r;
                    bitmap_b_nxt = bitmap_b_r;
                end
            endcase
        end
    end

    // Field storage registers.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            bitmap_a_r <= `BITMAP_RESET;
            bitmap_b_r <= `BITMAP_RESET;
        end else begin
            bitmap_a_r <= bitmap_a_nxt;
            bitmap_b_r <= bitmap_b_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Response registers.

    logic valid_r;
    logic valid_nxt;
    logic invalid_r;
    logic invalid_nxt;
    logic is_64_r;
    logic is_64_nxt;
    logic is_16_r;
    logic is_16_nxt;
    logic is_ctrl_r;
    logic is_ctrl_nxt;
    logic is_guest_r;
    logic is_guest_nxt;
    logic high_r;
    logic high_nxt;
    logic [8:0] index_r;
    logic [8:0] index_nxt;
    field_dec_pkg::sel_e sel_r;
    field_dec_pkg::sel_e sel_nxt;
    logic [63:0] rdata_r;
    logic [63:0] rdata_nxt;

    // Every accepted request yields one response pulse a cycle later.
    // Classification flags report what the encoding claims even when the
    // combination is unsupported, which helps software debug bad codes.
    always_comb begin
        valid_nxt = req_valid;
        invalid_nxt = 1'b0;
        is_64_nxt = 1'b0;
        is_16_nxt = 1'b0;
        is_ctrl_nxt = 1'b0;
        is_guest_nxt = 1'b0;
        high_nxt = 1'b0;
        index_nxt = 9'h000;
        sel_nxt = field_dec_pkg::SEL_NONE;
        rdata_nxt = 64'h0000_0000_0000_0000;
        if (req_valid) begin
            invalid_nxt = dec_invalid; // see RULE_11
            is_64_nxt = (dec_width == field_dec_pkg::WIDTH_64); // see RULE_01
            is_16_nxt = (dec_width == field_dec_pkg::WIDTH_16); // see RULE_10
            is_ctrl_nxt = (dec_type == field_dec_pkg::TYPE_CTRL); // see RULE_05
            is_guest_nxt = (dec_type == field_dec_pkg::TYPE_GUEST); // see RULE_09
            high_nxt = dec_high; // see RULE_03
            index_nxt = dec_index; // see RULE_06
            if (!dec_invalid) begin
                sel_nxt = dec_sel; // see RULE_11
            end
            if (!req_write && !dec_invalid) begin
                case (dec_sel)
                    field_dec_pkg::SEL_BITMAP_A: begin
                        rdata_nxt = read_view(bitmap_a_r,
                                              dec_high); // see RULE_04
                    end
                    field_dec_pkg::SEL_BITMAP_B: begin
                        rdata_nxt = read_view(bitmap_b_r,
                                              dec_high); // see RULE_04
                    end
                    default: begin
                        rdata_nxt = 64'h0000_0000_0000_0000;
                    end
                endcase
            end
        end
    end

    // Response pipeline stage.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            valid_r <= 1'b0;
            invalid_r <= 1'b0;
            is_64_r <= 1'b0;
            is_16_r <= 1'b0;
            is_ctrl_r <= 1'b0;
            is_guest_r <= 1'b0;
            high_r <= 1'b0;
            index_r <= 9'h000;
            sel_r <= field_dec_pkg::SEL_NONE;
            rdata_r <= 64'h0000_0000_0000_0000;
        end else begin
            valid_r <= valid_nxt;
            invalid_r <= invalid_nxt;
            is_64_r <= is_64_nxt;
            is_16_r <= is_16_nxt;
            is_ctrl_r <= is_ctrl_nxt;
            is_guest_r <= is_guest_nxt;
            high_r <= high_nxt;
            index_r <= index_nxt;
            sel_r <= sel_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Invalid-encoding event counter.

    logic [15:0] inv_cnt_r;
    logic [15:0] inv_cnt_nxt;

    // Saturates rather than wraps so a flood of bad codes stays visible.
    always_comb begin
        inv_cnt_nxt = inv_cnt_r;
        if (req_valid && dec_invalid && (inv_cnt_r != 16'hFFFF)) begin
            inv_cnt_nxt = inv_cnt_r + 16'h0001;
        end
    end

    // Counter register.
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            inv_cnt_r <= 16'h0000;
        end else begin
            inv_cnt_r <= inv_cnt_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, all straight from flip-flops.

    assign rsp_valid = valid_r;
    assign rsp_invalid = invalid_r;
    assign rsp_is_64 = is_64_r;
    assign rsp_is_16 = is_16_r;
    assign rsp_is_ctrl = is_ctrl_r;
    assign rsp_is_guest = is_guest_r;
    assign rsp_high = high_r;
    assign rsp_index = index_r;
    assign rsp_sel = sel_r;
    assign rsp_rdata = rdata_r;
    assign invalid_count = inv_cnt_r;

endmodule // wide_vm_field_encoding_decoder

// [tb/field_dec_checker.sv]
// Watches the decoder ports; every answer is judged one edge after a request.
module field_dec_checker (
    input wire logic core_clk,
    input wire logic nrst,
    input wire logic req_valid,
    input wire logic [31:0] req_enc,
    input wire logic rsp_valid,
    input wire logic rsp_invalid,
    input wire logic rsp_is_64,
    input wire logic rsp_is_16,
    input wire logic rsp_is_ctrl,
    input wire logic rsp_is_guest,
    input wire logic rsp_high,
    input wire logic [8:0] rsp_index,
    input wire field_dec_pkg::sel_e rsp_sel
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////////////////////////////////////
    // Each flag is tied to the encoding taken at the edge before it.
    a_width_wide: assert property (req_valid |=>
        rsp_is_64 == ($past(req_enc[14:13]) == 2'h1)) else $error("is_64");
    a_width_narrow: assert property (req_valid |=>
        rsp_is_16 == ($past(req_enc[14:13]) == 2'h0)) else $error("is_16");
    a_type_ctrl: assert property (req_valid |=>
        rsp_is_ctrl == ($past(req_enc[11:10]) == 2'h0)) else $error("ctrl");
    a_type_guest: assert property (req_valid |=>
        rsp_is_guest == ($past(req_enc[11:10]) == 2'h2)) else $error("guest");
    a_index_copy: assert property (req_valid |=>
        rsp_index == $past(req_enc[9:1])) else $error("index");
    a_high_half: assert property (req_valid |=>
        rsp_high == $past(req_enc[0])) else $error("high");
    a_valid_map: assert property (req_valid |=> rsp_valid &&
        rsp_invalid != ($past(req_enc) inside {[32'h0000_2000:32'h0000_2003]}))
        else $error("invalid flag");
    a_sel_map: assert property (req_valid |=>
        rsp_sel == (rsp_invalid ? field_dec_pkg::SEL_NONE : $past(req_enc[1])
        ? field_dec_pkg::SEL_BITMAP_B : field_dec_pkg::SEL_BITMAP_A))
        else $error("sel");
    // A quiet cycle must not leave a stale selection behind.
    a_quiet_idle: assert property (!req_valid |=>
        !rsp_valid && rsp_sel == field_dec_pkg::SEL_NONE) else $error("idle");
    c_refused: cover property (rsp_valid && rsp_invalid);
    c_upper_b: cover property (rsp_sel == field_dec_pkg::SEL_BITMAP_B && rsp_high);
    c_burst: cover property (req_valid [*3]);
endmodule // field_dec_checker

bind wide_vm_field_encoding_decoder field_dec_checker u_chk (.*);

// [tb/field_requester.sv]
// Issues field reads and writes as the instruction path does.
module field_requester (
    output logic req_valid,
    output logic req_write,
    output logic [31:0] req_enc,
    output logic [63:0] req_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {req_valid, req_write, req_enc, req_wdata} = '0;
    end
    // Request and its qualifiers change together and hold until replaced.
    task automatic issue(input logic w, input logic [31:0] e,
                         input logic [63:0] d);
        {req_valid, req_write, req_enc, req_wdata} = {1'h1, w, e, d};
    endtask
    // Released encoding and data lines show junk, so a design reading them idle is caught.
    task automatic idle();
        req_valid = 1'h0;
        req_enc = ~req_enc;
        req_wdata = ~req_wdata;
    endtask
endmodule // field_requester

// [tb/tb_top.sv]
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'h0;
    logic nrst = 1'h0;
    logic req_valid;
    logic req_write;
    logic [31:0] req_enc;
    logic [63:0] req_wdata;
    logic rsp_valid;
    logic rsp_invalid;
    logic rsp_is_64;
    logic rsp_is_16;
    logic rsp_is_ctrl;
    logic rsp_is_guest;
    logic rsp_high;
    logic [8:0] rsp_index;
    field_dec_pkg::sel_e rsp_sel;
    logic [63:0] rsp_rdata;
    logic [15:0] invalid_count;
    int fail_count = 0;
    int n_compared = 0;
    logic [63:0] a_m = '0;
    logic [63:0] b_m = '0;
    logic [15:0] ic = '0;
    logic [31:0] e;
    logic [31:0] bad [6] = '{32'h0000_2004, 32'h0000_2401, 32'h0000_2800,
        32'h0000_0000, 32'h0000_3000, 32'h0001_2000};
    always #4 core_clk = ~core_clk;
    wide_vm_field_encoding_decoder DUT (.*);
    field_requester u_req (.*);
    ////////////////////////////////////////////////////////////////////////
    // Upper-half reads return the high word in the low half.
    function automatic logic [63:0] pick(input logic [31:0] enc);
        logic [63:0] f;
        f = enc[1] ? b_m : a_m;
        return enc[0] ? {32'h0000_0000, f[63:32]} : f;
    endfunction
    // Flags as the width and type codes and the index field define them.
    function automatic logic [13:0] class_of(input logic [31:0] enc);
        return {enc[14:13] == 2'h1, enc[14:13] == 2'h0, enc[11:10] == 2'h0,
            enc[11:10] == 2'h2, enc[0], enc[9:1]};
    endfunction
    // Classification flags are compared apart from data and status.
    task automatic chk_class(input logic [13:0] got, input logic [13:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t flags %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk(input logic [83:0] got, input logic [83:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t answer %h not %h", $time, got, exp);
        end
    endtask
    // Fixed one-cycle answer, so no wait is needed beyond one edge.
    task automatic xfer(input logic w, input logic [31:0] enc,
                        input logic [63:0] d);
        logic ok;
        logic [1:0] s;
        logic [83:0] x;
        logic [83:0] g;
        logic [13:0] c;
        ok = enc inside {[32'h0000_2000:32'h0000_2003]};
        s = ok ? (enc[1] ? 2'h2 : 2'h1) : 2'h0;
        if (!ok && ic != 16'hffff) ic++;
        x = {1'h1, !ok, s, ic, (w || !ok) ? 64'h0 : pick(enc)};
        if (ok && w && enc[1]) b_m = enc[0] ? {d[31:0], b_m[31:0]} : d;
        if (ok && w && !enc[1]) a_m = enc[0] ? {d[31:0], a_m[31:0]} : d;
        u_req.issue(w, enc, d);
        @(posedge core_clk);
        #1;
        g = {rsp_valid, rsp_invalid, rsp_sel, invalid_count, rsp_rdata};
        c = {rsp_is_64, rsp_is_16, rsp_is_ctrl, rsp_is_guest, rsp_high,
            rsp_index};
        chk(g, x);
        chk_class(c, class_of(enc));
    endtask
    task automatic rest(input string name);
        u_req.idle();
        @(posedge core_clk);
        #1;
        $display("test %s done", name);
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // Main sequence: fields, refusals, random traffic back to back, then a mid-run reset.
    initial begin
        void'($urandom(60));
        repeat (4) @(posedge core_clk);
        #1;
        nrst = 1'h1;
        chk({rsp_valid, rsp_invalid, rsp_sel, invalid_count, rsp_rdata},
            '0);
        xfer(1'h0, 32'h0000_2000, '0);
        xfer(1'h1, 32'h0000_2000, {$urandom, $urandom});
        xfer(1'h1, 32'h0000_2002, {$urandom, $urandom});
        xfer(1'h1, 32'h0000_2001, {$urandom, $urandom});
        xfer(1'h1, 32'h0000_2003, {$urandom, $urandom});
        for (int i = 0; i < 4; i++) xfer(1'h0, 32'h0000_2000 + 32'(i), '0);
        rest("fields");
        foreach (bad[j]) xfer(1'(j), bad[j], {$urandom, $urandom});
        for (int i = 0; i < 4; i++) xfer(1'h0, 32'h0000_2000 + 32'(i), '0);
        rest("refusals");
        repeat (60) begin
            e = $urandom_range(1, 0) ? 32'h0000_2000 | ($urandom & 32'h3)
                : $urandom & 32'h0000_7fff;
            xfer(1'($urandom), e, {$urandom, $urandom});
        end
        rest("random");
        // Mid-run reset must clear both stored fields and the counter.
        nrst = 1'h0;
        repeat (2) @(posedge core_clk);
        #1;
        nrst = 1'h1;
        {a_m, b_m, ic} = '0;
        chk({rsp_valid, rsp_invalid, rsp_sel, invalid_count, rsp_rdata},
            '0);
        for (int i = 0; i < 4; i++) begin
            xfer(1'h0, 32'h0000_2000 + 32'(i), '0);
        end
        rest("reset");
        final_report();
    end
    // Cuts a hang short.
    initial begin
        #100000;
        fail_count++;
        final_report();
    end
endmodule // tb_top
